// [core/sqrc_top.sv]
`timescale 1ns/1ps
module sqrc_top
  import sqrc_pkg::*;
#(
  parameter int NUM_CH = SQRC_NUM_CH
) (
  // clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      nrst,
  // register port
  input  wire sqrc_pkg::sqrc_reg_req_t   reg_req,
  output logic [7:0]                     reg_rdata,
  output logic                           reg_rvalid,
  // fabric reset inputs
  input  wire sqrc_pkg::sqrc_rst_in_t    rst_in,
  // rate configuration per channel and reference clock setting
  output sqrc_pkg::sqrc_dir_cfg_t [NUM_CH-1:0] tx_cfg,
  output sqrc_pkg::sqrc_dir_cfg_t [NUM_CH-1:0] rx_cfg,
  output logic [1:0]                     refclk_mode,
  output logic [4:0]                     ref_mult,
  output logic [3:0]                     ref_div,
  // effective resets
  output logic                           xcvr_rst,
  output logic                           coding_rst,
  output logic [NUM_CH-1:0]              tx_coding_rst,
  output logic [NUM_CH-1:0]              rx_coding_rst
);
  import sqrc_pkg::*;

  typedef struct packed {
    logic [NUM_CH-1:0][7:0]         chan_rate;
    logic [7:0]                     bus_width;
    logic [7:0]                     refclk;
    logic [7:0]                     lane_rst;
    logic [7:0]                     xcvr_rst;
    logic [7:0]                     rst_en;
    logic [7:0]                     group_rst;
    logic [7:0]                     rdata;
    logic                           rvalid;
    sqrc_dir_cfg_t [NUM_CH-1:0]     tx_cfg;
    sqrc_dir_cfg_t [NUM_CH-1:0]     rx_cfg;
    logic [1:0]                     mode;
    logic [4:0]                     mult;
    logic [3:0]                     div;
  } sqrc_state_t;

  sqrc_state_t s_q;
  sqrc_state_t s_d;

  // parallel clock from rate and bus width
  function automatic sqrc_pclk_t pclk_of(input logic full, input logic wide);
    if (full) begin
      pclk_of = wide ? SQRC_PCLK_106M : SQRC_PCLK_212M;
    end else begin
      pclk_of = wide ? SQRC_PCLK_53M : SQRC_PCLK_106M;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register file and rate decode

  // one rate register, written to all channels alike
  // a read returns the copy held for channel 0

  always_comb begin
    s_d        = s_q;
    s_d.rvalid = 1'b0;
    if (reg_req.wr) begin
      unique case (reg_req.addr)
        SQRC_CHAN_RATE_OFS: begin
          for (int c = 0; c < NUM_CH; c++) begin
            s_d.chan_rate[c] = reg_req.wdata;
          end
        end
        SQRC_BUS_WIDTH_OFS: s_d.bus_width = reg_req.wdata;
        SQRC_REFCLK_OFS:    s_d.refclk    = reg_req.wdata;
        SQRC_LANE_RST_OFS:  s_d.lane_rst  = reg_req.wdata;
        SQRC_XCVR_RST_OFS:  s_d.xcvr_rst  = reg_req.wdata;
        SQRC_RST_EN_OFS:    s_d.rst_en    = reg_req.wdata;
        SQRC_GROUP_RST_OFS: s_d.group_rst = reg_req.wdata;
        default: ;
      endcase
    end
    if (reg_req.rd) begin
      s_d.rvalid = 1'b1;
      unique case (reg_req.addr)
        SQRC_CHAN_RATE_OFS: s_d.rdata = s_q.chan_rate[0];
        SQRC_BUS_WIDTH_OFS: s_d.rdata = s_q.bus_width;
        SQRC_REFCLK_OFS:    s_d.rdata = s_q.refclk;
        SQRC_LANE_RST_OFS:  s_d.rdata = s_q.lane_rst;
        SQRC_XCVR_RST_OFS:  s_d.rdata = s_q.xcvr_rst;
        SQRC_RST_EN_OFS:    s_d.rdata = s_q.rst_en;
        SQRC_GROUP_RST_OFS: s_d.rdata = s_q.group_rst;
        default:            s_d.rdata = 8'h00;
      endcase
    end
    // rate decode from current registers
    for (int c = 0; c < NUM_CH; c++) begin
      s_d.tx_cfg[c].full_rate = ~s_q.chan_rate[c][SQRC_TX_HALF_BIT];
      s_d.rx_cfg[c].full_rate = ~s_q.chan_rate[c][SQRC_RX_HALF_BIT];
      s_d.tx_cfg[c].wide_bus  = s_q.bus_width[SQRC_TX_WIDE_BIT];
      s_d.rx_cfg[c].wide_bus  = s_q.bus_width[SQRC_RX_WIDE_BIT];
      s_d.tx_cfg[c].pclk = pclk_of(~s_q.chan_rate[c][SQRC_TX_HALF_BIT],
                                   s_q.bus_width[SQRC_TX_WIDE_BIT]);
      s_d.rx_cfg[c].pclk = pclk_of(~s_q.chan_rate[c][SQRC_RX_HALF_BIT],
                                   s_q.bus_width[SQRC_RX_WIDE_BIT]);
    end
    // reference multiple to reach 1.0625 GHz half-rate bit clock
    s_d.mode = s_q.refclk[SQRC_REFMODE_LSB +: 2];
    unique case (s_q.refclk[SQRC_REFMODE_LSB +: 2])
      SQRC_REF_106M: begin
        s_d.mult = SQRC_MULT_106M_HALF;
        s_d.div  = 4'h1;
      end
      SQRC_REF_212M: begin
        s_d.mult = SQRC_MULT_212M_HALF;
        s_d.div  = 4'h1;
      end
      SQRC_REF_425M: begin
        s_d.mult = 5'h0a;
        s_d.div  = SQRC_DIV_425M_HALF;
      end
      default: begin
        s_d.mult = SQRC_MULT_106M_HALF;
        s_d.div  = 4'h1;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_q           <= '0;
      s_q.chan_rate <= {NUM_CH{SQRC_CHAN_RATE_RST}};
      s_q.bus_width <= SQRC_BUS_WIDTH_RST;
      s_q.refclk    <= SQRC_REFCLK_RST;
      s_q.lane_rst  <= SQRC_LANE_RST_RST;
      s_q.xcvr_rst  <= SQRC_XCVR_RST_RST;
      s_q.rst_en    <= SQRC_RST_EN_RST;
      s_q.group_rst <= SQRC_GROUP_RST_RST;
      s_q.mult      <= SQRC_MULT_106M_HALF;
      s_q.div       <= 4'h1;
      for (int c = 0; c < NUM_CH; c++) begin
        s_q.tx_cfg[c] <= '{full_rate: 1'b1, wide_bus: 1'b0, pclk: SQRC_PCLK_212M};
        s_q.rx_cfg[c] <= '{full_rate: 1'b1, wide_bus: 1'b0, pclk: SQRC_PCLK_212M};
      end
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // effective resets

  logic                pin_en;
  logic                quad_req;
  logic                xcvr_req;
  logic [NUM_CH-1:0]   tx_req;
  logic [NUM_CH-1:0]   rx_req;
  logic                quad_sync;
  logic                xcvr_sync;
  logic [NUM_CH-1:0]   tx_sync;
  logic [NUM_CH-1:0]   rx_sync;

  // requests set the resets at once; release waits for the synchroniser
  assign pin_en   = s_q.rst_en[SQRC_RST_EN_BIT];
  assign quad_req = ~nrst | (pin_en & rst_in.quad)
                  | s_q.group_rst[SQRC_GROUP_RST_BIT];
  assign xcvr_req = quad_req | (pin_en & rst_in.xcvr)
                  | s_q.xcvr_rst[SQRC_XCVR_RST_BIT];

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    assign tx_req[c] = quad_req | (pin_en & rst_in.tx[c])
                     | s_q.lane_rst[SQRC_TX_RST_CH0 - c];
    assign rx_req[c] = quad_req | (pin_en & rst_in.rx[c])
                     | s_q.lane_rst[SQRC_RX_RST_CH0 - c];
    sqrc_rst_sync #(.STAGES(SQRC_SYNC_STAGES)) u_tx (
      .clk     (core_clk),
      .rst_req (tx_req[c]),
      .rst_out (tx_sync[c])
    );
    sqrc_rst_sync #(.STAGES(SQRC_SYNC_STAGES)) u_rx (
      .clk     (core_clk),
      .rst_req (rx_req[c]),
      .rst_out (rx_sync[c])
    );
  end

  sqrc_rst_sync #(.STAGES(SQRC_SYNC_STAGES)) u_quad (
    .clk     (core_clk),
    .rst_req (quad_req),
    .rst_out (quad_sync)
  );
  sqrc_rst_sync #(.STAGES(SQRC_SYNC_STAGES)) u_xcvr (
    .clk     (core_clk),
    .rst_req (xcvr_req),
    .rst_out (xcvr_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign reg_rdata     = s_q.rdata;
  assign reg_rvalid    = s_q.rvalid;
  assign tx_cfg        = s_q.tx_cfg;
  assign rx_cfg        = s_q.rx_cfg;
  assign refclk_mode   = s_q.mode;
  assign ref_mult      = s_q.mult;
  assign ref_div       = s_q.div;
  assign xcvr_rst      = xcvr_sync;
  assign coding_rst    = quad_sync;
  assign tx_coding_rst = tx_sync;
  assign rx_coding_rst = rx_sync;
endmodule

// [core/sqrc_pkg.sv]
package sqrc_pkg;

  // register offsets
  localparam logic [7:0] SQRC_CHAN_RATE_OFS  = 8'h13;
  localparam logic [7:0] SQRC_BUS_WIDTH_OFS  = 8'h19;
  localparam logic [7:0] SQRC_REFCLK_OFS     = 8'h28;
  localparam logic [7:0] SQRC_LANE_RST_OFS   = 8'h40;
  localparam logic [7:0] SQRC_XCVR_RST_OFS   = 8'h41;
  localparam logic [7:0] SQRC_RST_EN_OFS     = 8'h42;
  localparam logic [7:0] SQRC_GROUP_RST_OFS  = 8'h43;

  // field positions
  localparam int SQRC_TX_HALF_BIT   = 5;
  localparam int SQRC_RX_HALF_BIT   = 4;
  localparam int SQRC_TX_WIDE_BIT   = 4;
  localparam int SQRC_RX_WIDE_BIT   = 5;
  localparam int SQRC_REFMODE_LSB   = 2;
  localparam int SQRC_XCVR_RST_BIT  = 5;
  localparam int SQRC_RST_EN_BIT    = 7;
  localparam int SQRC_GROUP_RST_BIT = 7;
  localparam int SQRC_TX_RST_CH0    = 7;
  localparam int SQRC_RX_RST_CH0    = 3;
  localparam int SQRC_NUM_CH        = 4;
  localparam int SQRC_SYNC_STAGES   = 2;

  // reset values
  localparam logic [7:0] SQRC_CHAN_RATE_RST = 8'h00;
  localparam logic [7:0] SQRC_BUS_WIDTH_RST = 8'h00;
  localparam logic [7:0] SQRC_REFCLK_RST    = 8'h00;
  localparam logic [7:0] SQRC_LANE_RST_RST  = 8'h00;
  localparam logic [7:0] SQRC_XCVR_RST_RST  = 8'h20;
  localparam logic [7:0] SQRC_RST_EN_RST    = 8'h80;
  localparam logic [7:0] SQRC_GROUP_RST_RST = 8'h00;

  // reference clock mode codes
  localparam logic [1:0] SQRC_REF_106M = 2'h0;
  localparam logic [1:0] SQRC_REF_212M = 2'h1;
  localparam logic [1:0] SQRC_REF_425M = 2'h2;

  // reference multiplier and divider giving the internal bit clock (half rate only)
  localparam logic [4:0] SQRC_MULT_106M_HALF = 5'h0a;
  localparam logic [4:0] SQRC_MULT_212M_HALF = 5'h05;
  localparam logic [3:0] SQRC_DIV_425M_HALF  = 4'h4;

  // parallel clock code: divider of bit clock, 0 = 1.0625g/20, 1 = 1.0625g/10 etc.
  typedef enum logic [1:0] {
    SQRC_PCLK_53M  = 2'h0,
    SQRC_PCLK_106M = 2'h1,
    SQRC_PCLK_212M = 2'h2
  } sqrc_pclk_t;

  // register read/write port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sqrc_reg_req_t;

  // fabric reset inputs
  typedef struct packed {
    logic                   quad;
    logic                   xcvr;
    logic [SQRC_NUM_CH-1:0] tx;
    logic [SQRC_NUM_CH-1:0] rx;
  } sqrc_rst_in_t;

  // per-direction rate configuration
  typedef struct packed {
    logic       full_rate;
    logic       wide_bus;
    sqrc_pclk_t pclk;
  } sqrc_dir_cfg_t;

endpackage

// [core/sqrc_rst_sync.sv]
`timescale 1ns/1ps
module sqrc_rst_sync #(
  parameter int STAGES = 2
) (
  // clock and reset request
  input  wire logic clk,
  input  wire logic rst_req,
  // synchronised reset
  output logic      rst_out
);
  import sqrc_pkg::*;

  typedef struct packed {
    logic [STAGES-1:0] sh;
  } sqrc_sync_state_t;

  sqrc_sync_state_t s_q;
  sqrc_sync_state_t s_d;

  always_comb begin
    s_d    = s_q;
    s_d.sh = {s_q.sh[STAGES-2:0], 1'b0};
  end

  // asserts at once, releases after STAGES edges
  always_ff @(posedge clk or posedge rst_req) begin
    if (rst_req) begin
      s_q <= '{sh: {STAGES{1'b1}}};
    end else begin
      s_q <= s_d;
    end
  end

  assign rst_out = s_q.sh[STAGES-1];
endmodule

// [sim/sqrc_top_sva.sv]
`timescale 1ns/1ps
module sqrc_top_sva
  import sqrc_pkg::*;
#(
  parameter int NUM_CH = SQRC_NUM_CH
) (
  // clock and reset
  input wire logic                              core_clk,
  input wire logic                              nrst,
  // register port
  input wire sqrc_pkg::sqrc_reg_req_t           reg_req,
  input wire logic                              reg_rvalid,
  // resets and config
  input wire sqrc_pkg::sqrc_rst_in_t            rst_in,
  input wire sqrc_pkg::sqrc_dir_cfg_t [NUM_CH-1:0] tx_cfg,
  input wire sqrc_pkg::sqrc_dir_cfg_t [NUM_CH-1:0] rx_cfg,
  input wire logic                              xcvr_rst,
  input wire logic                              coding_rst,
  input wire logic [NUM_CH-1:0]                 tx_coding_rst,
  input wire logic [NUM_CH-1:0]                 rx_coding_rst
);
  logic              en_q, grp_q, xcv_q, quad_req, xcvr_req;
  logic [7:0]        lane_q;
  logic [NUM_CH-1:0] tx_req, rx_req;
  ////////////////////////////////////////
  // shadow of the reset control bits
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      en_q <= 1'b1;
      grp_q <= 1'b0;
      xcv_q <= 1'b1;
      lane_q <= 8'h00;
    end else if (reg_req.wr) begin
      if (reg_req.addr == SQRC_RST_EN_OFS) en_q <= reg_req.wdata[7];
      if (reg_req.addr == SQRC_GROUP_RST_OFS) grp_q <= reg_req.wdata[7];
      if (reg_req.addr == SQRC_XCVR_RST_OFS) xcv_q <= reg_req.wdata[5];
      if (reg_req.addr == SQRC_LANE_RST_OFS) lane_q <= reg_req.wdata;
    end
  end
  always_comb begin
    quad_req = (rst_in.quad & en_q) | grp_q;
    xcvr_req = quad_req | (rst_in.xcvr & en_q) | xcv_q;
    for (int c = 0; c < NUM_CH; c++) begin
      tx_req[c] = quad_req | (rst_in.tx[c] & en_q) | lane_q[SQRC_TX_RST_CH0-c];
      rx_req[c] = quad_req | (rst_in.rx[c] & en_q) | lane_q[SQRC_RX_RST_CH0-c];
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_req_drop;
    quad_req ##1 !quad_req;
  endsequence
  a_read_answer: assert property (reg_req.rd |=> reg_rvalid) else $error("no read answer");
  a_quad_all: assert property (quad_req |-> coding_rst && xcvr_rst && (&tx_coding_rst)
    && (&rx_coding_rst)) else $error("quad reset not applied");
  a_quad_hold: assert property (s_req_drop |-> coding_rst)
    else $error("quad reset released early");
  a_quad_release: assert property (s_req_drop ##1 !quad_req |=> !coding_rst)
    else $error("quad reset release late");
  a_pin_ignored: assert property (!quad_req [*3] |-> !coding_rst)
    else $error("quad reset without request");
  a_xcvr_req: assert property (xcvr_req |-> xcvr_rst) else $error("xcvr reset missing");
  a_lane_map: assert property (
    ((tx_req & ~tx_coding_rst) | (rx_req & ~rx_coding_rst)) == '0)
    else $error("channel reset missing");
  a_rate_write: assert property (reg_req.wr && reg_req.addr == SQRC_CHAN_RATE_OFS |-> ##2
    tx_cfg[NUM_CH-1].full_rate == !$past(reg_req.wdata[SQRC_TX_HALF_BIT], 2)
    && rx_cfg[0].full_rate == !$past(reg_req.wdata[SQRC_RX_HALF_BIT], 2))
    else $error("rate select not applied");
endmodule
bind sqrc_top sqrc_top_sva #(.NUM_CH(NUM_CH)) u_sva (.core_clk(core_clk), .nrst(nrst),
  .reg_req(reg_req), .reg_rvalid(reg_rvalid), .rst_in(rst_in), .tx_cfg(tx_cfg),
  .rx_cfg(rx_cfg), .xcvr_rst(xcvr_rst), .coding_rst(coding_rst),
  .tx_coding_rst(tx_coding_rst), .rx_coding_rst(rx_coding_rst));

// [sim/sqrc_fabric_model.sv]
`timescale 1ns/1ps
module sqrc_fabric_model (
  // clock
  input  wire logic                   core_clk,
  // requested and driven resets
  input  wire sqrc_pkg::sqrc_rst_in_t cmd,
  output sqrc_pkg::sqrc_rst_in_t      rst_in
);
  import sqrc_pkg::*;
  // fabric logic drives its reset levels off the sampling edge
  always @(negedge core_clk) rst_in <= cmd;
endmodule

// [sim/serdes_quad_rate_and_reset_control_tb.sv]
`timescale 1ns/1ps
module serdes_quad_rate_and_reset_control_tb;
  import sqrc_pkg::*;
  logic               core_clk, nrst, reg_rvalid, xcvr_rst, coding_rst;
  sqrc_reg_req_t      req;
  sqrc_rst_in_t       cmd, rst_in;
  sqrc_dir_cfg_t [3:0] tx_cfg, rx_cfg;
  logic [7:0]         reg_rdata, w13, w19, w40, wen, wgrp;
  logic [1:0]         refclk_mode;
  logic [4:0]         ref_mult;
  logic [3:0]         ref_div, tx_coding_rst, rx_coding_rst;
  int                 n_errors, n_checks, seed;
  int                 cyc = 0;
  sqrc_top dut (.core_clk(core_clk), .nrst(nrst), .reg_req(req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .rst_in(rst_in), .tx_cfg(tx_cfg), .rx_cfg(rx_cfg),
    .refclk_mode(refclk_mode), .ref_mult(ref_mult), .ref_div(ref_div), .xcvr_rst(xcvr_rst),
    .coding_rst(coding_rst), .tx_coding_rst(tx_coding_rst), .rx_coding_rst(rx_coding_rst));
  sqrc_fabric_model fab (.core_clk(core_clk), .cmd(cmd), .rst_in(rst_in));
  ////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk) req <= '{1'b1, 1'b0, a, d};
    @(negedge core_clk) req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge core_clk) req <= '{1'b0, 1'b1, a, 8'h00};
    @(negedge core_clk) req <= '0;
    chk(16'(reg_rvalid), 16'h1);
    chk(16'(reg_rdata), 16'(exp));
  endtask
  ////////////////////////////////////////
  function automatic sqrc_dir_cfg_t exp_cfg(input logic half, input logic wide);
    exp_cfg.full_rate = !half;
    exp_cfg.wide_bus = wide;
    exp_cfg.pclk = half ? (wide ? SQRC_PCLK_53M : SQRC_PCLK_106M)
                        : (wide ? SQRC_PCLK_106M : SQRC_PCLK_212M);
  endfunction
  function automatic logic [8:0] exp_ref(input logic [1:0] m);
    return (m == 2'h1) ? {5'h05, 4'h1} : (m == 2'h2) ? {5'h0a, 4'h4} : {5'h0a, 4'h1};
  endfunction
  function automatic logic [9:0] exp_rst(input sqrc_rst_in_t p, input logic en,
                                         input logic grp, input logic [7:0] lane);
    logic       q;
    logic [3:0] t, r;
    q = (p.quad & en) | grp;
    for (int c = 0; c < 4; c++) begin
      t[c] = q | (p.tx[c] & en) | lane[7-c];
      r[c] = q | (p.rx[c] & en) | lane[3-c];
    end
    return {q, q | (p.xcvr & en), t, r};
  endfunction
  ////////////////////////////////////////
  initial begin
    seed = 38492;
    n_errors = 0;
    n_checks = 0;
    nrst = 1'b0;
    req = '0;
    cmd = '0;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    nrst = 1'b1;
    rd(SQRC_CHAN_RATE_OFS, 8'h00);
    rd(SQRC_XCVR_RST_OFS, 8'h20);
    rd(SQRC_RST_EN_OFS, 8'h80);
    rd(SQRC_GROUP_RST_OFS, 8'h00);
    rd(SQRC_LANE_RST_OFS, 8'h00);
    rd(8'h55, 8'h00);
    chk(16'({coding_rst, xcvr_rst}), 16'h1);
    wr(SQRC_XCVR_RST_OFS, 8'h00);
    repeat (3) @(negedge core_clk);
    chk(16'(xcvr_rst), 16'h0);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      w13 = (i < 2) ? 8'(i * 8'h30) : 8'($random(seed)) & 8'h30;
      w19 = 8'($random(seed)) & 8'h30;
      wr(SQRC_CHAN_RATE_OFS, w13);
      wr(SQRC_BUS_WIDTH_OFS, w19);
      wr(SQRC_REFCLK_OFS, {4'h0, 2'(i), 2'h0});
      repeat (2) @(negedge core_clk);
      for (int c = 0; c < 4; c++) begin
        chk(16'(tx_cfg[c]), 16'(exp_cfg(w13[5], w19[4])));
        chk(16'(rx_cfg[c]), 16'(exp_cfg(w13[4], w19[5])));
      end
      chk(16'({refclk_mode, ref_mult, ref_div}), 16'({2'(i), exp_ref(2'(i))}));
      rd(SQRC_BUS_WIDTH_OFS, w19);
    end
    $display("rate test done");
    for (int i = 0; i < 10; i++) begin
      wen = (i == 7) ? 8'h80 : (i == 8) ? 8'h00 : 8'($random(seed)) & 8'h80;
      w40 = 8'($random(seed));
      wgrp = (i == 4) ? 8'h80 : 8'h00;
      wr(SQRC_RST_EN_OFS, wen);
      wr(SQRC_LANE_RST_OFS, w40);
      wr(SQRC_GROUP_RST_OFS, wgrp);
      cmd <= {(i == 7) || (i == 8), 9'($random(seed))};
      repeat (4) @(negedge core_clk);
      chk(16'({coding_rst, xcvr_rst, tx_coding_rst, rx_coding_rst}),
          16'(exp_rst(cmd, wen[7], wgrp[7], w40)));
    end
    cmd <= '0;
    wr(SQRC_LANE_RST_OFS, 8'h00);
    repeat (3) @(negedge core_clk);
    chk(16'({coding_rst, xcvr_rst, tx_coding_rst, rx_coding_rst}), 16'h0);
    @(negedge core_clk) nrst = 1'b0;
    @(negedge core_clk);
    chk(16'({coding_rst, xcvr_rst, tx_coding_rst, rx_coding_rst}), 16'h3ff);
    nrst = 1'b1;
    rd(SQRC_XCVR_RST_OFS, 8'h20);
    rd(SQRC_RST_EN_OFS, 8'h80);
    $display("reset path test done");
    test_done();
  end
endmodule
